// *** verif/ess_encoder_model.sv ***
// Behavioural quadrature encoder on the motor shaft
`timescale 1ns/1ps
module ess_encoder_model #(
	parameter int STEP = 4
) (
	input  wire logic clock,
	input  wire logic run,
	input  wire logic fwd,
	input  wire logic attached,
	output logic      enc_a,
	output logic      enc_b,
	output logic      card_present
);
	logic [1:0] phase_ff = 2'h0;
	int         cnt_ff   = 0;
	// Forward order 00,10,11,01: A leads B
	assign enc_a        = phase_ff[0] ^ phase_ff[1];
	assign enc_b        = phase_ff[1];
	assign card_present = attached;
	always @(posedge clock) begin
		if (run) begin
			if (cnt_ff == STEP - 1) begin
				cnt_ff   <= 0;
				phase_ff <= fwd ? phase_ff + 2'h1 : phase_ff - 2'h1;
			end else begin
				cnt_ff <= cnt_ff + 1;
			end
		end
	end
endmodule // ess_encoder_model

// *** verif/ess_top_monitor.sv ***
// Assertion checker bound to the encoder speed supervisor top
`timescale 1ns/1ps
module ess_top_monitor (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	input wire logic primary_port_monitor_pulse,
	input wire logic stop_req,
	input wire logic overspeed_alarm,
	input wire logic deviation_alarm_flash,
	input wire logic overspeed_fault,
	input wire logic speed_deviation_fault
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	logic wb_wr;
	assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i;

	property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack held too long");
	property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
	property p_os_alarm; overspeed_alarm |-> $past(overspeed_fault); endproperty
	a_os_alarm: assert property (p_os_alarm) else $error("stray overspeed alarm");
	property p_flash; deviation_alarm_flash |-> $past(speed_deviation_fault); endproperty
	a_flash: assert property (p_flash) else $error("stray deviation flash");
	property p_stop;
		$rose(stop_req) |-> $past(overspeed_fault) || $past(speed_deviation_fault);
	endproperty
	a_stop: assert property (p_stop) else $error("stop without fault");
	property p_os_hold; overspeed_fault && !wb_wr |=> overspeed_fault; endproperty
	a_os_hold: assert property (p_os_hold) else $error("overspeed fault lost");
	property p_dev_hold; speed_deviation_fault && !wb_wr |=> speed_deviation_fault; endproperty
	a_dev_hold: assert property (p_dev_hold) else $error("deviation fault lost");
	property p_mon; primary_port_monitor_pulse |=> !primary_port_monitor_pulse; endproperty
	a_mon: assert property (p_mon) else $error("monitor pulse too long");
endmodule // ess_top_monitor

bind ess_top ess_top_monitor u_ess_top_monitor (
	.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
	.primary_port_monitor_pulse(primary_port_monitor_pulse), .stop_req(stop_req),
	.overspeed_alarm(overspeed_alarm), .deviation_alarm_flash(deviation_alarm_flash),
	.overspeed_fault(overspeed_fault), .speed_deviation_fault(speed_deviation_fault)
);

// *** verif/testbench.sv ***
// Self-checking bench for the encoder speed supervisor
`timescale 1ns/1ps
module testbench
	import ess_pkg::*;
;
	logic        clock = 1'b0, sys_rst = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0, rdat;
	logic        ack, pa, pb, pc, sa, sb, sc, pmon, smon;
	logic [15:0] speed_ref = 16'h0;
	logic        m2act = 1'b0, pm = 1'b0, run = 1'b1, fwd = 1'b1;
	logic        att1 = 1'b1, att2 = 1'b1;
	logic        stop_req, os_al, dev_fl, os_f, dev_f, d1_f, d2_f;
	logic [1:0]  stop_mode;
	int          n_errors = 0, cmp_count = 0, mon_cnt = 0, smon_cnt = 0;

	initial forever #2.5 clock = ~clock;

	ess_top #(.GATE_CYCLES(64), .TICK_CYCLES(32)) u_ess_top (
		.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.primary_port_enc_a(pa), .primary_port_enc_b(pb), .primary_port_card_present(pc),
		.secondary_port_enc_a(sa), .secondary_port_enc_b(sb),
		.secondary_port_card_present(sc), .primary_port_monitor_pulse(pmon),
		.secondary_port_monitor_pulse(smon), .speed_ref(speed_ref), .motor2_active(m2act),
		.pm_motor(pm), .stop_req(stop_req), .stop_mode(stop_mode), .overspeed_alarm(os_al),
		.deviation_alarm_flash(dev_fl), .overspeed_fault(os_f),
		.speed_deviation_fault(dev_f), .primary_port_disconnect_fault(d1_f),
		.secondary_port_disconnect_fault(d2_f));
	ess_encoder_model u_enc1 (.clock(clock), .run(run), .fwd(fwd), .attached(att1),
		.enc_a(pa), .enc_b(pb), .card_present(pc));
	ess_encoder_model u_enc2 (.clock(clock), .run(run), .fwd(fwd), .attached(att2),
		.enc_a(sa), .enc_b(sb), .card_present(sc));

	always @(posedge clock) if (pmon === 1'b1) mon_cnt <= mon_cnt + 1;
	always @(posedge clock) if (smon === 1'b1) smon_cnt <= smon_cnt + 1;

	task automatic final_report();
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			chk("wait_done", 32'h1, 32'h0);
			final_report();
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		tmo(n, 20);
		@(posedge clock);
	endtask

	task automatic t_reset();
		logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h10, 8'h1c, 8'h30};
		logic [31:0] rv [8] = '{32'h1d, 32'ha0073, 32'h5000a, 32'h104, 32'h104, 32'h0,
			32'h3e8, 32'h0};
		logic [31:0] q;
		chk("stop_mode", 32'h1, stop_mode);
		for (int i = 0; i < 8; i++) begin
			wb(1'b0, ra[i], 32'h0, q);
			chk("reg_reset", rv[i], q);
		end
	endtask

	task automatic t_speed();
		logic [31:0] q;
		wb(1'b1, ADDR_PORT1_CFG, 32'h106, q);
		repeat (150) @(posedge clock);
		wb(1'b0, ADDR_SPEED, 32'h0, q);
		chk("speed", 32'h00040008, q);
		wb(1'b0, ADDR_STATUS, 32'h0, q);
		chk("fwd", 32'h3, q[5:4]);
		fwd <= 1'b0;
		repeat (150) @(posedge clock);
		wb(1'b0, ADDR_STATUS, 32'h0, q);
		chk("rev_dir0", 32'h0, q[4]);
		wb(1'b1, ADDR_PORT1_CFG, 32'h107, q);
		repeat (40) @(posedge clock);
		wb(1'b0, ADDR_STATUS, 32'h0, q);
		chk("rev_dir1", 32'h1, q[4]);
		fwd <= 1'b1;
		wb(1'b1, ADDR_PORT1_CFG, 32'h106, q);
	endtask

	task automatic t_fault(input logic dv, input logic [1:0] act);
		logic [31:0] q;
		int n;
		wb(1'b1, ADDR_CTRL, dv ? {28'h1, act, 2'h1} : {28'h1, 2'h3, act}, q);
		wb(1'b1, ADDR_STATUS, 32'h3, q);
		for (n = 0; n < 800 && (dv ? dev_f : os_f) !== 1'b1; n++) @(posedge clock);
		tmo(n, 800);
		repeat (2) @(posedge clock);
		if (act != 2'h3) begin
			chk("stop_req", 32'h1, stop_req);
			chk("stop_mode", act, stop_mode);
		end else if (!dv) begin
			chk("os_alarm", 32'h1, os_al);
		end else begin
			for (n = 0; n < 100 && dev_fl !== 1'b1; n++) @(posedge clock);
			tmo(n, 100);
		end
	endtask

	task automatic t_mon(input logic [7:0] dv, input int ex);
		logic [31:0] q;
		int m0;
		int s0;
		run <= 1'b0;
		wb(1'b1, ADDR_PORT1_CFG, {16'h0, dv, 8'h06}, q);
		repeat (20) @(posedge clock);
		m0 = mon_cnt;
		s0 = smon_cnt;
		run <= 1'b1;
		repeat (512) @(posedge clock);
		run <= 1'b0;
		repeat (20) @(posedge clock);
		chk("mon_pulses", ex, mon_cnt - m0);
		chk("mon2_pulses", 32'd32, smon_cnt - s0);
	endtask

	task automatic t_restart();
		logic [31:0] q;
		speed_ref <= 16'h8;
		wb(1'b1, ADDR_STATUS, 32'h3, q);
		repeat (3) begin
			speed_ref <= 16'h0;
			repeat (100) @(posedge clock);
			speed_ref <= 16'h8;
			repeat (20) @(posedge clock);
		end
		chk("dev_restart", 32'h0, dev_f);
	endtask

	task automatic t_disc();
		logic [31:0] q;
		int n;
		wb(1'b1, ADDR_PORT2_CFG, 32'h100, q);
		att1 <= 1'b0;
		att2 <= 1'b0;
		for (n = 0; n < 40 && d1_f !== 1'b1; n++) @(posedge clock);
		tmo(n, 40);
		repeat (10) @(posedge clock);
		chk("disc2_off", 32'h0, d2_f);
		att1 <= 1'b1;
		att2 <= 1'b1;
		repeat (8) @(posedge clock);
		wb(1'b1, ADDR_STATUS, 32'hc, q);
		chk("disc1_clr", 32'h0, d1_f);
	endtask

	task automatic t_m2();
		logic [2:0]  cs [3] = '{3'b101, 3'b110, 3'b000};
		logic [31:0] q;
		m2act <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			pm <= cs[i][1];
			wb(1'b1, ADDR_CTRL, {27'h0, cs[i][2], 4'hd}, q);
			repeat (3) @(posedge clock);
			wb(1'b0, ADDR_STATUS, 32'h0, q);
			chk("fb_port2", cs[i][0], q[6]);
		end
		m2act <= 1'b0;
	endtask

	initial begin
		logic [31:0] q;
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		t_reset();
		t_speed();
		wb(1'b1, ADDR_FULL_SCALE, 32'h4, q);
		wb(1'b1, ADDR_OS_CFG, 32'h00020078, q);
		speed_ref <= 16'h8;
		wb(1'b1, ADDR_PORT1_GEAR, 32'h00020001, q);
		wb(1'b1, ADDR_STATUS, 32'h3, q);
		repeat (300) @(posedge clock);
		chk("os_geared", 32'h0, os_f);
		wb(1'b1, ADDR_PORT1_GEAR, 32'h0, q);
		for (int i = 0; i < 4; i++) t_fault(1'b0, i[1:0]);
		wb(1'b1, ADDR_FULL_SCALE, 32'h10, q);
		speed_ref <= 16'h0;
		for (int i = 0; i < 4; i++) t_fault(1'b1, i[1:0]);
		t_restart();
		t_mon(8'h01, 32);
		t_mon(8'h02, 16);
		t_mon(8'h84, 2);
		run <= 1'b1;
		t_disc();
		t_m2();
		final_report();
	end
endmodule // testbench

// *** verilog/ess_fault_timer.sv ***
// Level-exceed delay timer with sticky fault flag
`timescale 1ns/1ps
module ess_fault_timer
	import ess_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       exceed,
	input  wire logic       tick,
	input  wire logic [6:0] delay,
	input  wire logic       clear,
	output logic            fault_ff
);
	logic [6:0] cnt_ff;
	wire        expired = exceed & tick & (cnt_ff >= delay);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cnt_ff   <= 7'h00;
			fault_ff <= 1'b0;
		end else begin
			if (!exceed)
				cnt_ff <= 7'h00;
			else if (tick && cnt_ff != 7'h7f)
				cnt_ff <= cnt_ff + 7'h01;
			// Set wins over clear
			fault_ff <= expired | (fault_ff & ~clear);
		end
	end
endmodule // ess_fault_timer

// *** verilog/ess_pkg.sv ***
// Constants, field layout and types shared by the encoder speed supervisor
package ess_pkg;

	// Clock and time base
	localparam int CLK_MHZ            = 200;
	localparam int SPEED_GATE_US      = 1000;
	localparam int SPEED_GATE_CYCLES  = CLK_MHZ * SPEED_GATE_US;
	localparam int DELAY_TICK_MS      = 100;
	localparam int DELAY_TICK_CYCLES  = CLK_MHZ * 1000 * DELAY_TICK_MS;

	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL       = 8'h00;
	localparam logic [7:0] ADDR_OS_CFG     = 8'h04;
	localparam logic [7:0] ADDR_DEV_CFG    = 8'h08;
	localparam logic [7:0] ADDR_PORT1_CFG  = 8'h0c;
	localparam logic [7:0] ADDR_PORT1_GEAR = 8'h10;
	localparam logic [7:0] ADDR_PORT2_CFG  = 8'h14;
	localparam logic [7:0] ADDR_PORT2_GEAR = 8'h18;
	localparam logic [7:0] ADDR_FULL_SCALE = 8'h1c;
	localparam logic [7:0] ADDR_STATUS     = 8'h20;
	localparam logic [7:0] ADDR_SPEED      = 8'h24;

	// Control register fields
	localparam int CTRL_OS_ACT_LSB  = 0;
	localparam int CTRL_DEV_ACT_LSB = 2;
	localparam int CTRL_M2SEL_BIT   = 4;

	// Level and delay fields
	localparam int LEVEL_LSB = 0;
	localparam int DELAY_LSB = 16;

	// Port configuration fields
	localparam int PCFG_DIR_BIT  = 0;
	localparam int PCFG_CHAN_BIT = 1;
	localparam int PCFG_DISC_BIT = 2;
	localparam int PCFG_DIV_LSB  = 8;
	localparam int GEAR_MOTOR_LSB = 0;
	localparam int GEAR_LOAD_LSB  = 16;

	// Status bits
	localparam int ST_OS_BIT    = 0;
	localparam int ST_DEV_BIT   = 1;
	localparam int ST_DISC1_BIT = 2;
	localparam int ST_DISC2_BIT = 3;
	localparam int ST_FWD1_BIT  = 4;
	localparam int ST_FWD2_BIT  = 5;
	localparam int ST_FBP2_BIT  = 6;

	// Limits
	localparam logic [6:0] OS_LEVEL_MAX  = 7'h78;
	localparam logic [6:0] DEV_LEVEL_MAX = 7'h32;
	localparam logic [6:0] OS_DELAY_MAX  = 7'h14;
	localparam logic [6:0] DEV_DELAY_MAX = 7'h64;
	localparam logic [6:0] PCT_FULL      = 7'h64;
	localparam logic [7:0] DIV_HUNDRED   = 8'h64;

	// Reset values
	localparam logic [1:0]  OS_ACT_RST     = 2'h1;
	localparam logic [1:0]  DEV_ACT_RST    = 2'h3;
	localparam logic        M2SEL_RST      = 1'b1;
	localparam logic [6:0]  OS_LEVEL_RST   = 7'h73;
	localparam logic [6:0]  OS_DELAY_RST   = 7'h0a;
	localparam logic [6:0]  DEV_LEVEL_RST  = 7'h0a;
	localparam logic [6:0]  DEV_DELAY_RST  = 7'h05;
	localparam logic        DIR_RST        = 1'b0;
	localparam logic        CHAN_RST       = 1'b0;
	localparam logic        DISC_RST       = 1'b1;
	localparam logic [7:0]  DIV_RST        = 8'h01;
	localparam logic [9:0]  TEETH_RST      = 10'h000;
	localparam logic [15:0] FULL_SCALE_RST = 16'h03e8;

	typedef enum logic [1:0] {
		ESS_RAMP,
		ESS_COAST,
		ESS_FAST,
		ESS_ALARM
	} ess_action_t;

endpackage

// *** verilog/ess_port.sv ***
// One pulse encoder port: pin sync, decode, speed count, pulse monitor
`timescale 1ns/1ps
module ess_port
	import ess_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        enc_a,
	input  wire logic        enc_b,
	input  wire logic        card_present,
	input  wire logic        gate_tick,
	input  wire logic        direction_sel,
	input  wire logic        channel_sel,
	input  wire logic [7:0]  monitor_divider,
	output logic [15:0]      speed_count_ff,
	output logic             forward_ff,
	output logic             card_missing_ff,
	output logic             monitor_pulse_ff
);
	logic [2:0]  a_sync_ff;
	logic [2:0]  b_sync_ff;
	logic [2:0]  p_sync_ff;
	logic        a_stable_ff;
	logic        b_stable_ff;
	logic        p_stable_ff;
	logic [15:0] pulse_cnt_ff;
	logic [6:0]  mon_acc_ff;

	// Edges count once the second and third stages agree
	wire a_agree = a_sync_ff[1] == a_sync_ff[2];
	wire b_agree = b_sync_ff[1] == b_sync_ff[2];
	wire p_agree = p_sync_ff[1] == p_sync_ff[2];
	wire a_rise  = a_agree & a_sync_ff[2] & ~a_stable_ff;
	wire b_rise  = b_agree & b_sync_ff[2] & ~b_stable_ff;

	// Single channel counts A only, two channel counts A and B
	wire         b_counts  = channel_sel & b_rise;
	wire [1:0]   inc       = {1'b0, a_rise} + {1'b0, b_counts};
	wire [16:0]  cnt_sum   = {1'b0, pulse_cnt_ff} + {15'h0000, inc};
	wire [15:0]  cnt_sat   = cnt_sum[16] ? 16'hffff : cnt_sum[15:0];
	wire         a_leads   = ~b_stable_ff;

	// Divider digits: n is the hundreds digit, m the last two
	wire         div_n     = monitor_divider >= DIV_HUNDRED;
	wire [7:0]   div_m_raw = monitor_divider - (div_n ? DIV_HUNDRED : 8'h00);
	wire [6:0]   div_m     = (div_m_raw == 8'h00) ? 7'h01 : div_m_raw[6:0];
	wire [6:0]   mon_add   = a_rise ? {5'h00, 1'b0, 1'b1} + {6'h00, div_n} : 7'h00;
	wire [6:0]   mon_sum   = mon_acc_ff + mon_add;
	wire         mon_fire  = mon_sum >= div_m;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			a_sync_ff   <= 3'h0;
			b_sync_ff   <= 3'h0;
			p_sync_ff   <= 3'h7;
			a_stable_ff <= 1'b0;
			b_stable_ff <= 1'b0;
			p_stable_ff <= 1'b1;
		end else begin
			a_sync_ff <= {a_sync_ff[1:0], enc_a};
			b_sync_ff <= {b_sync_ff[1:0], enc_b};
			p_sync_ff <= {p_sync_ff[1:0], card_present};
			if (a_agree)
				a_stable_ff <= a_sync_ff[2];
			if (b_agree)
				b_stable_ff <= b_sync_ff[2];
			if (p_agree)
				p_stable_ff <= p_sync_ff[2];
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pulse_cnt_ff   <= 16'h0000;
			speed_count_ff <= 16'h0000;
		end else if (gate_tick) begin
			speed_count_ff <= cnt_sat;
			pulse_cnt_ff   <= 16'h0000;
		end else begin
			pulse_cnt_ff <= cnt_sat;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			forward_ff      <= 1'b1;
			card_missing_ff <= 1'b0;
		end else begin
			if (a_rise)
				forward_ff <= channel_sel ? (a_leads ^ direction_sel) : 1'b1;
			card_missing_ff <= ~p_stable_ff;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			mon_acc_ff       <= 7'h00;
			monitor_pulse_ff <= 1'b0;
		end else begin
			mon_acc_ff       <= mon_fire ? mon_sum - div_m : mon_sum;
			monitor_pulse_ff <= mon_fire;
		end
	end
endmodule // ess_port

// *** verilog/ess_top.sv ***
// Encoder speed supervisor: registers, port select, fault detection
`timescale 1ns/1ps
// What this block does
// - Overspeed fault when scaled speed stays above a level (max 120%, reset 115%) past a delay up to 2.0 s.
// - Overspeed action code 0 ramp, 1 coast (reset), 2 fast stop, 3 alarm only and keep running.
// - Deviation fault when the difference between reference and speed, either sign, exceeds a level (max 50%, reset 10%) past a delay (reset 0.5 s).
// - Deviation action uses the same codes, resets to 3, and code 3 only flashes a deviation alarm.
// - Per port, with channel select 1, direction 0 means A leading is forward and 1 means B leading is forward; channel select 0 always reports forward.
// - Pulse monitor divider 1..132 splits into digit n and digits m and sets the monitor pulse rate.
// - Speed is scaled by motor teeth over load teeth, with ratio one when either count is zero.
// - Per port, disconnect detection is off at 0 and on at 1, and resets on.
// - Per port, channel select 0 counts A only and 1 uses both A and B, resetting to 0.
// - Motor 2 feedback comes from the primary port at 0 and the secondary port at 1, resetting to 1.
// - Motor 2 feedback switching is disabled for permanent-magnet motors.
module ess_top
	import ess_pkg::*;
#(
	parameter int GATE_CYCLES = SPEED_GATE_CYCLES,
	parameter int TICK_CYCLES = DELAY_TICK_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        primary_port_enc_a,
	input  wire logic        primary_port_enc_b,
	input  wire logic        primary_port_card_present,
	input  wire logic        secondary_port_enc_a,
	input  wire logic        secondary_port_enc_b,
	input  wire logic        secondary_port_card_present,
	output logic             primary_port_monitor_pulse,
	output logic             secondary_port_monitor_pulse,
	input  wire logic [15:0] speed_ref,
	input  wire logic        motor2_active,
	input  wire logic        pm_motor,
	output logic             stop_req,
	output logic [1:0]       stop_mode,
	output logic             overspeed_alarm,
	output logic             deviation_alarm_flash,
	output logic             overspeed_fault,
	output logic             speed_deviation_fault,
	output logic             primary_port_disconnect_fault,
	output logic             secondary_port_disconnect_fault
);

	function automatic logic [31:0] wb_merge(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] sel);
		logic [31:0] mask;
		mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old_val & ~mask) | (new_val & mask);
	endfunction

	function automatic logic [6:0] clamp7(input logic [6:0] val, input logic [6:0] lim);
		return (val > lim) ? lim : val;
	endfunction

	function automatic logic [9:0] teeth_eff(input logic [9:0] val, input logic one);
		return one ? 10'h001 : val;
	endfunction

	localparam logic [31:0] CTRL_RST = 32'(M2SEL_RST) << CTRL_M2SEL_BIT
		| 32'(DEV_ACT_RST) << CTRL_DEV_ACT_LSB | 32'(OS_ACT_RST) << CTRL_OS_ACT_LSB;
	localparam logic [31:0] OS_RST   = 32'(OS_DELAY_RST) << DELAY_LSB
		| 32'(OS_LEVEL_RST) << LEVEL_LSB;
	localparam logic [31:0] DEV_RST  = 32'(DEV_DELAY_RST) << DELAY_LSB
		| 32'(DEV_LEVEL_RST) << LEVEL_LSB;
	localparam logic [31:0] PCFG_RST = 32'(DIV_RST) << PCFG_DIV_LSB
		| 32'(DISC_RST) << PCFG_DISC_BIT | 32'(CHAN_RST) << PCFG_CHAN_BIT
		| 32'(DIR_RST) << PCFG_DIR_BIT;
	localparam logic [31:0] GEAR_RST = 32'(TEETH_RST) << GEAR_LOAD_LSB
		| 32'(TEETH_RST) << GEAR_MOTOR_LSB;

	// Register file
	logic [31:0] ctrl_ff;
	logic [31:0] os_cfg_ff;
	logic [31:0] dev_cfg_ff;
	logic [31:0] pcfg_ff [2];
	logic [31:0] gear_ff [2];
	logic [15:0] full_scale_ff;
	logic        ack_ff;
	logic [31:0] dat_ff;

	wire        bus_req   = wb_cyc_i & wb_stb_i & ~ack_ff;
	// Write lands on the edge where the master sees ack
	wire        wr_en     = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
	wire        sel_ctrl  = wb_adr_i == ADDR_CTRL;
	wire        sel_os    = wb_adr_i == ADDR_OS_CFG;
	wire        sel_dev   = wb_adr_i == ADDR_DEV_CFG;
	wire        sel_p1c   = wb_adr_i == ADDR_PORT1_CFG;
	wire        sel_p1g   = wb_adr_i == ADDR_PORT1_GEAR;
	wire        sel_p2c   = wb_adr_i == ADDR_PORT2_CFG;
	wire        sel_p2g   = wb_adr_i == ADDR_PORT2_GEAR;
	wire        sel_fs    = wb_adr_i == ADDR_FULL_SCALE;
	wire        sel_st    = wb_adr_i == ADDR_STATUS;
	wire        sel_spd   = wb_adr_i == ADDR_SPEED;
	wire [1:0]  sel_pcfg  = {sel_p2c, sel_p1c};
	wire [1:0]  sel_gear  = {sel_p2g, sel_p1g};
	wire [31:0] clear_bits = (wr_en & sel_st) ? wb_merge(32'h0, wb_dat_i, wb_sel_i) : 32'h0;
	wire [31:0] fs_merge   = wb_merge({16'h0000, full_scale_ff}, wb_dat_i, wb_sel_i);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctrl_ff       <= CTRL_RST;
			os_cfg_ff     <= OS_RST;
			dev_cfg_ff    <= DEV_RST;
			full_scale_ff <= FULL_SCALE_RST;
		end else if (wr_en) begin
			if (sel_ctrl)
				ctrl_ff <= wb_merge(ctrl_ff, wb_dat_i, wb_sel_i);
			if (sel_os)
				os_cfg_ff <= wb_merge(os_cfg_ff, wb_dat_i, wb_sel_i);
			if (sel_dev)
				dev_cfg_ff <= wb_merge(dev_cfg_ff, wb_dat_i, wb_sel_i);
			if (sel_fs)
				full_scale_ff <= fs_merge[15:0];
		end
	end

	// Per-port configuration and encoder logic
	logic [1:0]  enc_a;
	logic [1:0]  enc_b;
	logic [1:0]  card_present;
	logic [15:0] port_speed [2];
	logic [1:0]  port_fwd;
	logic [1:0]  port_missing;
	logic [1:0]  port_monitor;
	logic [1:0]  disc_fault_ff;
	logic        gate_tick;

	assign enc_a        = {secondary_port_enc_a, primary_port_enc_a};
	assign enc_b        = {secondary_port_enc_b, primary_port_enc_b};
	assign card_present = {secondary_port_card_present, primary_port_card_present};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_port
			always_ff @(posedge clock) begin
				if (sys_rst) begin
					pcfg_ff[gi] <= PCFG_RST;
					gear_ff[gi] <= GEAR_RST;
				end else if (wr_en) begin
					if (sel_pcfg[gi])
						pcfg_ff[gi] <= wb_merge(pcfg_ff[gi], wb_dat_i, wb_sel_i);
					if (sel_gear[gi])
						gear_ff[gi] <= wb_merge(gear_ff[gi], wb_dat_i, wb_sel_i);
				end
			end

			always_ff @(posedge clock) begin
				if (sys_rst)
					disc_fault_ff[gi] <= 1'b0;
				else
					disc_fault_ff[gi] <= (port_missing[gi] & pcfg_ff[gi][PCFG_DISC_BIT])
						| (disc_fault_ff[gi] & ~clear_bits[ST_DISC1_BIT + gi]);
			end

			ess_port u_port (
				.clock            (clock),
				.sys_rst          (sys_rst),
				.enc_a            (enc_a[gi]),
				.enc_b            (enc_b[gi]),
				.card_present     (card_present[gi]),
				.gate_tick        (gate_tick),
				.direction_sel    (pcfg_ff[gi][PCFG_DIR_BIT]),
				.channel_sel      (pcfg_ff[gi][PCFG_CHAN_BIT]),
				.monitor_divider  (pcfg_ff[gi][PCFG_DIV_LSB +: 8]),
				.speed_count_ff   (port_speed[gi]),
				.forward_ff       (port_fwd[gi]),
				.card_missing_ff  (port_missing[gi]),
				.monitor_pulse_ff (port_monitor[gi])
			);
		end
	endgenerate

	assign primary_port_monitor_pulse   = port_monitor[0];
	assign secondary_port_monitor_pulse = port_monitor[1];
	assign primary_port_disconnect_fault   = disc_fault_ff[0];
	assign secondary_port_disconnect_fault = disc_fault_ff[1];

	// Rate dividers for speed gate and delay tick
	logic [31:0] gate_cnt_ff;
	logic [31:0] tick_cnt_ff;
	wire         delay_tick = tick_cnt_ff == 32'(TICK_CYCLES - 1);
	assign gate_tick = gate_cnt_ff == 32'(GATE_CYCLES - 1);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			gate_cnt_ff <= 32'h0;
			tick_cnt_ff <= 32'h0;
		end else begin
			gate_cnt_ff <= gate_tick ? 32'h0 : gate_cnt_ff + 32'h1;
			tick_cnt_ff <= delay_tick ? 32'h0 : tick_cnt_ff + 32'h1;
		end
	end

	// Feedback port choice
	wire fb_port2 = motor2_active & ctrl_ff[CTRL_M2SEL_BIT] & ~pm_motor;
	wire [15:0] fb_speed = fb_port2 ? port_speed[1] : port_speed[0];
	wire [31:0] fb_gear  = fb_port2 ? gear_ff[1] : gear_ff[0];
	wire [9:0]  motor_t  = fb_gear[GEAR_MOTOR_LSB +: 10];
	wire [9:0]  load_t   = fb_gear[GEAR_LOAD_LSB +: 10];
	wire        ratio_one = (motor_t == 10'h000) | (load_t == 10'h000);
	wire [9:0]  motor_e  = teeth_eff(motor_t, ratio_one);
	wire [9:0]  load_e   = teeth_eff(load_t, ratio_one);

	// Comparisons scaled by load teeth to avoid division
	wire [6:0]  os_level  = clamp7(os_cfg_ff[LEVEL_LSB +: 7], OS_LEVEL_MAX);
	wire [6:0]  os_delay  = clamp7(os_cfg_ff[DELAY_LSB +: 7], OS_DELAY_MAX);
	wire [6:0]  dev_level = clamp7(dev_cfg_ff[LEVEL_LSB +: 7], DEV_LEVEL_MAX);
	wire [6:0]  dev_delay = clamp7(dev_cfg_ff[DELAY_LSB +: 7], DEV_DELAY_MAX);
	wire [39:0] spd_m     = 40'(fb_speed) * 40'(motor_e);
	wire [39:0] ref_l     = 40'(speed_ref) * 40'(load_e);
	wire [39:0] fs_l      = 40'(full_scale_ff) * 40'(load_e);
	wire [39:0] diff      = (ref_l > spd_m) ? ref_l - spd_m : spd_m - ref_l;
	wire        os_exceed  = spd_m * 40'(PCT_FULL) > fs_l * 40'(os_level);
	wire        dev_exceed = diff * 40'(PCT_FULL) > fs_l * 40'(dev_level);

	ess_fault_timer u_os_timer (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.exceed   (os_exceed),
		.tick     (delay_tick),
		.delay    (os_delay),
		.clear    (clear_bits[ST_OS_BIT]),
		.fault_ff (overspeed_fault)
	);

	ess_fault_timer u_dev_timer (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.exceed   (dev_exceed),
		.tick     (delay_tick),
		.delay    (dev_delay),
		.clear    (clear_bits[ST_DEV_BIT]),
		.fault_ff (speed_deviation_fault)
	);

	// Stopping actions; overspeed takes priority over deviation
	ess_action_t os_act;
	ess_action_t dev_act;
	logic        stop_req_ff;
	logic [1:0]  stop_mode_ff;
	logic        os_alarm_ff;
	logic        dev_flash_ff;

	assign os_act  = ess_action_t'(ctrl_ff[CTRL_OS_ACT_LSB +: 2]);
	assign dev_act = ess_action_t'(ctrl_ff[CTRL_DEV_ACT_LSB +: 2]);
	wire os_stop   = overspeed_fault & (os_act != ESS_ALARM);
	wire dev_stop  = speed_deviation_fault & (dev_act != ESS_ALARM);
	wire dev_alarm = speed_deviation_fault & (dev_act == ESS_ALARM);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			stop_req_ff  <= 1'b0;
			stop_mode_ff <= ESS_COAST;
			os_alarm_ff  <= 1'b0;
			dev_flash_ff <= 1'b0;
		end else begin
			stop_req_ff <= os_stop | dev_stop;
			if (os_stop)
				stop_mode_ff <= os_act;
			else if (dev_stop)
				stop_mode_ff <= dev_act;
			os_alarm_ff <= overspeed_fault & (os_act == ESS_ALARM);
			if (!dev_alarm)
				dev_flash_ff <= 1'b0;
			else if (delay_tick)
				dev_flash_ff <= ~dev_flash_ff;
		end
	end

	assign stop_req              = stop_req_ff;
	assign stop_mode             = stop_mode_ff;
	assign overspeed_alarm       = os_alarm_ff;
	assign deviation_alarm_flash = dev_flash_ff;

	// Read side
	wire [31:0] status_word = {25'h0, fb_port2, port_fwd, disc_fault_ff,
		speed_deviation_fault, overspeed_fault};
	wire [31:0] rd_mux =
		sel_ctrl ? ctrl_ff :
		sel_os   ? os_cfg_ff :
		sel_dev  ? dev_cfg_ff :
		sel_p1c  ? pcfg_ff[0] :
		sel_p1g  ? gear_ff[0] :
		sel_p2c  ? pcfg_ff[1] :
		sel_p2g  ? gear_ff[1] :
		sel_fs   ? {16'h0000, full_scale_ff} :
		sel_st   ? status_word :
		sel_spd  ? {port_speed[1], port_speed[0]} : 32'h0;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0;
		end else begin
			ack_ff <= bus_req;
			if (bus_req && !wb_we_i)
				dat_ff <= rd_mux;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;

endmodule // ess_top
